// ---- hdl/bei_pkg.sv ----
// shared constants, types and helpers for the bit error tester back end
package bei_pkg;
	// register data and address widths
	localparam int DATA_W = 16;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h60;
	localparam logic [ADDR_W-1:0] OFS_TEI    = 8'h68;
	localparam logic [ADDR_W-1:0] OFS_LIVE   = 8'h6c;
	localparam logic [ADDR_W-1:0] OFS_LATCH  = 8'h6e;
	localparam logic [ADDR_W-1:0] OFS_IRQEN  = 8'h70;
	localparam logic [ADDR_W-1:0] OFS_ERR_LO = 8'h74;
	localparam logic [ADDR_W-1:0] OFS_ERR_HI = 8'h76;
	localparam logic [ADDR_W-1:0] OFS_BIT_LO = 8'h78;
	localparam logic [ADDR_W-1:0] OFS_BIT_HI = 8'h7a;

	// control register fields
	localparam int CTRL_MODE_BIT  = 7;
	localparam int CTRL_LOCAL_BIT = 6;

	// error insertion control fields
	localparam int TEI_RATE_LSB   = 3;
	localparam int TEI_RATE_W     = 3;
	localparam int TEI_ENABLE_BIT = 2;
	localparam int TEI_TRIG_BIT   = 1;
	localparam int TEI_SRC_BIT    = 0;

	// status, latched status and enable share one layout
	localparam int ST_W           = 4;
	localparam int ST_UPDATE_BIT  = 3;
	localparam int ST_BITERR_BIT  = 2;
	localparam int ST_NONZERO_BIT = 1;
	localparam int ST_SYNC_BIT    = 0;

	// counter widths and sync depth
	localparam int ERR_CNT_W   = 24;
	localparam int BIT_CNT_W   = 32;
	localparam int RATE_CNT_W  = 24;
	localparam int SYNC_STAGES = 3;
	localparam logic [DATA_W-1:0] REG_RST = 16'h0000;

	// rate insertion state
	typedef enum logic [1:0]
	{
		BEI_RATE_IDLE = 2'b01,
		BEI_RATE_RUN  = 2'b10
	} bei_rate_e;

	// bits per inserted error for a rate field value
	function automatic logic [RATE_CNT_W-1:0] bei_pow10(input logic [TEI_RATE_W-1:0] n);
		logic [RATE_CNT_W-1:0] p;
		p = 24'h000001;
		unique case (n)
			3'h0: p = 24'h000001;
			3'h1: p = 24'h00000a;
			3'h2: p = 24'h000064;
			3'h3: p = 24'h0003e8;
			3'h4: p = 24'h002710;
			3'h5: p = 24'h0186a0;
			3'h6: p = 24'h0f4240;
			3'h7: p = 24'h989680;
		endcase
		return p;
	endfunction
endpackage

// ---- hdl/bei_sat_counter.sv ----
// saturating accumulator with restart that keeps a coincident increment
`timescale 1ns/1ps
module bei_sat_counter #(
	parameter int WIDTH = 24
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             inc_i,
	input  wire logic             restart_i,
	output logic [WIDTH-1:0]      count_o
);
	localparam logic [WIDTH-1:0] CNT_MAX = '1;
	localparam logic [WIDTH-1:0] CNT_ONE = WIDTH'(1);

	if (WIDTH < 2)
	begin : g_bad_width
		$error("bei_sat_counter: WIDTH must be at least 2");
	end

	// restart keeps the bit arriving in the same cycle so none is lost
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			count_o <= '0;
		else if (restart_i)
			count_o <= inc_i ? CNT_ONE : '0;
		else if (inc_i && count_o != CNT_MAX)
			count_o <= count_o + CNT_ONE;
	end

	property p_saturate;
		@(posedge clk_i) disable iff (rst_i)
		(count_o == CNT_MAX && !restart_i) |=> (count_o == CNT_MAX);
	endproperty
	a_saturate: assert property (p_saturate) else $error("counter left its maximum");

	property p_restart;
		@(posedge clk_i) disable iff (rst_i)
		(restart_i && !inc_i) |=> (count_o == '0);
	endproperty
	a_restart: assert property (p_restart) else $error("counter did not restart");
endmodule

// ---- hdl/bei_err_insert.sv ----
// transmit error insertion: rate based and single shot
`timescale 1ns/1ps
module bei_err_insert #(
	parameter int RATE_W = 3,
	parameter int CNT_W  = 24
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              bit_valid_i,
	input  wire logic [RATE_W-1:0] rate_i,
	input  wire logic              rate_wr_i,
	input  wire logic              single_en_i,
	input  wire logic              trigger_i,
	output logic                   invert_o
);
	if (RATE_W != bei_pkg::TEI_RATE_W || CNT_W != bei_pkg::RATE_CNT_W)
	begin : g_bad_param
		$error("bei_err_insert: widths must match the rate table");
	end

	bei_pkg::bei_rate_e   state_reg;
	logic [RATE_W-1:0]    rate_act_reg;
	logic [CNT_W-1:0]     cnt_reg;
	logic                 trig_d_reg;
	logic                 pend_reg;
	logic                 hit;
	logic                 rise;

	assign hit  = (state_reg == bei_pkg::BEI_RATE_RUN) && bit_valid_i
	              && (cnt_reg == bei_pkg::bei_pow10(rate_act_reg) - CNT_W'(1));
	assign rise = trigger_i && !trig_d_reg;
	assign invert_o = bit_valid_i && (hit || (pend_reg && single_en_i));

	// rate engine: a new nonzero rate waits until the current error is out; a zero rate stops it at once
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg    <= bei_pkg::BEI_RATE_IDLE;
			rate_act_reg <= '0;
			cnt_reg      <= '0;
		end
		else if (rate_wr_i && rate_i == '0)
			state_reg <= bei_pkg::BEI_RATE_IDLE;
		else
		begin
			unique case (state_reg)
				bei_pkg::BEI_RATE_IDLE:
					if (rate_wr_i)
					begin
						state_reg    <= bei_pkg::BEI_RATE_RUN;
						rate_act_reg <= rate_i;
						cnt_reg      <= '0;
					end
				bei_pkg::BEI_RATE_RUN:
					if (hit)
					begin
						cnt_reg      <= '0;
						rate_act_reg <= rate_i;
					end
					else if (bit_valid_i)
						cnt_reg <= cnt_reg + CNT_W'(1);
			endcase
		end
	end

	// single shot: several edges before one bit slot still make one error
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			trig_d_reg <= 1'b0;
			pend_reg   <= 1'b0;
		end
		else
		begin
			trig_d_reg <= trigger_i;
			pend_reg   <= single_en_i && ((pend_reg && !bit_valid_i) || rise);
		end
	end

	property p_idle_quiet;
		@(posedge clk_i) disable iff (rst_i)
		(state_reg == bei_pkg::BEI_RATE_IDLE && !(pend_reg && single_en_i)) |-> !invert_o;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("error inserted while disabled");

	property p_single_once;
		@(posedge clk_i) disable iff (rst_i)
		(bit_valid_i && pend_reg && !rise) |=> !pend_reg;
	endproperty
	a_single_once: assert property (p_single_once) else $error("single error inserted twice");

	property p_single_gate;
		@(posedge clk_i) disable iff (rst_i)
		!single_en_i |=> !pend_reg;
	endproperty
	a_single_gate: assert property (p_single_gate) else $error("single error armed while disabled");
endmodule

// ---- hdl/bei_top.sv ----
// bit error tester back end: insertion, status, latched status and counters
`timescale 1ns/1ps
module bei_top (
	input  wire logic                       CORE_CLK_I,
	input  wire logic                       RST_I,
	input  wire logic [bei_pkg::ADDR_W-1:0] REG_ADDR_I,
	input  wire logic [bei_pkg::DATA_W-1:0] REG_WDATA_I,
	input  wire logic                       REG_WR_I,
	input  wire logic                       REG_RD_I,
	output logic [bei_pkg::DATA_W-1:0]      REG_RDATA_O,
	output logic                            REG_RVALID_O,
	input  wire logic                       TX_BIT_VALID_I,
	input  wire logic                       TX_DATA_I,
	output logic                            TX_BIT_VALID_O,
	output logic                            TX_DATA_O,
	input  wire logic                       EXTERNAL_INSERT_INPUT_I,
	input  wire logic                       RX_BIT_VALID_I,
	input  wire logic                       RX_BIT_ERROR_I,
	input  wire logic                       RX_OUT_OF_SYNC_I,
	input  wire logic                       GLOBAL_UPDATE_SIGNAL_I,
	input  wire logic                       PORT_GLOBAL_IRQ_EN_I,
	output logic                            INT_O
);
	localparam int DW = bei_pkg::DATA_W;
	localparam int SW = bei_pkg::ST_W;
	localparam int EW = bei_pkg::ERR_CNT_W;
	localparam int BW = bei_pkg::BIT_CNT_W;

	logic [bei_pkg::SYNC_STAGES-1:0]  ext_sync_reg;
	logic                             ext_level_reg;
	logic                             update_mode_select_reg;
	logic                             local_update_request_reg;
	logic [bei_pkg::TEI_RATE_W-1:0]   insert_rate_field_reg;
	logic                             single_insert_enable_reg;
	logic                             single_insert_trigger_reg;
	logic                             insert_source_select_reg;
	logic                             tei_wr_d_reg;
	logic [SW-1:0]                    irq_en_reg;
	logic [SW-1:0]                    latched_reg;
	logic [SW-1:0]                    latch_set;
	logic [SW-1:0]                    latch_clr;
	logic                             update_done_flag_reg;
	logic                             error_count_nonzero_reg;
	logic                             out_of_sync_flag_reg;
	logic [SW-1:0]                    flags_d_reg;
	logic                             req_d_reg;
	logic                             sel_req;
	logic                             upd_pulse;
	logic                             err_inc;
	logic                             bit_inc;
	logic                             ins_invert;
	logic                             sel_trigger;
	logic                             irq_next;
	logic [EW-1:0]                    err_acc;
	logic [BW-1:0]                    received_bit_total;
	logic [EW-1:0]                    err_snap_reg;
	logic [BW-1:0]                    bit_snap_reg;
	logic [DW-1:0]                    rd_next;
	logic                             wr_ctrl;
	logic                             wr_tei;
	logic                             wr_latch;
	logic                             wr_irqen;

	// write decode
	assign wr_ctrl  = REG_WR_I && (REG_ADDR_I == bei_pkg::OFS_CTRL);
	assign wr_tei   = REG_WR_I && (REG_ADDR_I == bei_pkg::OFS_TEI);
	assign wr_latch = REG_WR_I && (REG_ADDR_I == bei_pkg::OFS_LATCH);
	assign wr_irqen = REG_WR_I && (REG_ADDR_I == bei_pkg::OFS_IRQEN);

	// external pin: three stages, a level is taken once stages two and three agree
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ext_sync_reg  <= '0;
			ext_level_reg <= 1'b0;
		end
		else
		begin
			ext_sync_reg <= {ext_sync_reg[bei_pkg::SYNC_STAGES-2:0], EXTERNAL_INSERT_INPUT_I};
			if (ext_sync_reg[bei_pkg::SYNC_STAGES-2] == ext_sync_reg[bei_pkg::SYNC_STAGES-1])
				ext_level_reg <= ext_sync_reg[bei_pkg::SYNC_STAGES-1];
		end
	end

	// control and insertion registers written by software
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			update_mode_select_reg    <= bei_pkg::REG_RST[bei_pkg::CTRL_MODE_BIT];
			local_update_request_reg  <= bei_pkg::REG_RST[bei_pkg::CTRL_LOCAL_BIT];
			insert_rate_field_reg     <= bei_pkg::REG_RST[bei_pkg::TEI_RATE_LSB +: bei_pkg::TEI_RATE_W];
			single_insert_enable_reg  <= bei_pkg::REG_RST[bei_pkg::TEI_ENABLE_BIT];
			single_insert_trigger_reg <= bei_pkg::REG_RST[bei_pkg::TEI_TRIG_BIT];
			insert_source_select_reg  <= bei_pkg::REG_RST[bei_pkg::TEI_SRC_BIT];
			irq_en_reg                <= bei_pkg::REG_RST[SW-1:0];
			tei_wr_d_reg              <= 1'b0;
		end
		else
		begin
			tei_wr_d_reg <= wr_tei;
			if (wr_ctrl)
			begin
				update_mode_select_reg   <= REG_WDATA_I[bei_pkg::CTRL_MODE_BIT];
				local_update_request_reg <= REG_WDATA_I[bei_pkg::CTRL_LOCAL_BIT];
			end
			if (wr_tei)
			begin
				insert_rate_field_reg     <= REG_WDATA_I[bei_pkg::TEI_RATE_LSB +: bei_pkg::TEI_RATE_W];
				single_insert_enable_reg  <= REG_WDATA_I[bei_pkg::TEI_ENABLE_BIT];
				single_insert_trigger_reg <= REG_WDATA_I[bei_pkg::TEI_TRIG_BIT];
				insert_source_select_reg  <= REG_WDATA_I[bei_pkg::TEI_SRC_BIT];
			end
			if (wr_irqen)
				irq_en_reg <= REG_WDATA_I[SW-1:0];
		end
	end

	// trigger source; a select change with a high trigger looks like an edge
	assign sel_trigger = insert_source_select_reg ? ext_level_reg : single_insert_trigger_reg;

	// rate write is seen one cycle late so the new field is in place; a running rate takes a nonzero field at its next error, a zero field stops it at once
	bei_err_insert #(
		.RATE_W (bei_pkg::TEI_RATE_W),
		.CNT_W  (bei_pkg::RATE_CNT_W)
	) u_insert (
		.clk_i       (CORE_CLK_I),
		.rst_i       (RST_I),
		.bit_valid_i (TX_BIT_VALID_I),
		.rate_i      (insert_rate_field_reg),
		.rate_wr_i   (tei_wr_d_reg),
		.single_en_i (single_insert_enable_reg),
		.trigger_i   (sel_trigger),
		.invert_o    (ins_invert)
	);

	// transmit path: one register stage, data inverted on an insertion slot
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			TX_BIT_VALID_O <= 1'b0;
			TX_DATA_O      <= 1'b0;
		end
		else
		begin
			TX_BIT_VALID_O <= TX_BIT_VALID_I;
			if (TX_BIT_VALID_I)
				TX_DATA_O <= TX_DATA_I ^ ins_invert;
		end
	end

	// receive counting is frozen while the pattern is out of sync
	assign err_inc   = RX_BIT_VALID_I && RX_BIT_ERROR_I && !RX_OUT_OF_SYNC_I;
	assign bit_inc   = RX_BIT_VALID_I && !RX_OUT_OF_SYNC_I;
	assign sel_req   = update_mode_select_reg ? GLOBAL_UPDATE_SIGNAL_I : local_update_request_reg;
	assign upd_pulse = sel_req && !req_d_reg;

	bei_sat_counter #(
		.WIDTH (EW)
	) u_err_acc (
		.clk_i     (CORE_CLK_I),
		.rst_i     (RST_I),
		.inc_i     (err_inc),
		.restart_i (upd_pulse),
		.count_o   (err_acc)
	);

	bei_sat_counter #(
		.WIDTH (BW)
	) u_bit_acc (
		.clk_i     (CORE_CLK_I),
		.rst_i     (RST_I),
		.inc_i     (bit_inc),
		.restart_i (upd_pulse),
		.count_o   (received_bit_total)
	);

	// snapshot and live flags; done flag rises with the snapshot itself
	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			req_d_reg               <= 1'b0;
			err_snap_reg            <= '0;
			bit_snap_reg            <= '0;
			update_done_flag_reg    <= 1'b0;
			error_count_nonzero_reg <= 1'b0;
			out_of_sync_flag_reg    <= 1'b0;
			flags_d_reg             <= '0;
		end
		else
		begin
			req_d_reg <= sel_req;
			if (upd_pulse)
			begin
				err_snap_reg <= err_acc;
				bit_snap_reg <= received_bit_total;
			end
			if (!sel_req)
				update_done_flag_reg <= 1'b0;
			else if (upd_pulse)
				update_done_flag_reg <= 1'b1;
			error_count_nonzero_reg <= (err_acc != '0);
			out_of_sync_flag_reg    <= RX_OUT_OF_SYNC_I;
			flags_d_reg[bei_pkg::ST_UPDATE_BIT]  <= update_done_flag_reg;
			flags_d_reg[bei_pkg::ST_BITERR_BIT]  <= 1'b0;
			flags_d_reg[bei_pkg::ST_NONZERO_BIT] <= error_count_nonzero_reg;
			flags_d_reg[bei_pkg::ST_SYNC_BIT]    <= out_of_sync_flag_reg;
		end
	end

	// latched events; a set in the clearing cycle wins
	always_comb
	begin
		latch_set = '0;
		latch_set[bei_pkg::ST_UPDATE_BIT]  = update_done_flag_reg && !flags_d_reg[bei_pkg::ST_UPDATE_BIT];
		latch_set[bei_pkg::ST_BITERR_BIT]  = err_inc;
		latch_set[bei_pkg::ST_NONZERO_BIT] = error_count_nonzero_reg
		                                     && !flags_d_reg[bei_pkg::ST_NONZERO_BIT];
		latch_set[bei_pkg::ST_SYNC_BIT]    = out_of_sync_flag_reg != flags_d_reg[bei_pkg::ST_SYNC_BIT];
		latch_clr = wr_latch ? REG_WDATA_I[SW-1:0] : '0;
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			latched_reg <= '0;
		else
			latched_reg <= (latched_reg & ~latch_clr) | latch_set;
	end

	// interrupt request; update-done skips the port gate
	assign irq_next = (latched_reg[bei_pkg::ST_UPDATE_BIT] && irq_en_reg[bei_pkg::ST_UPDATE_BIT])
	                  || (PORT_GLOBAL_IRQ_EN_I && ((latched_reg & irq_en_reg
	                  & ~(SW'(1) << bei_pkg::ST_UPDATE_BIT)) != '0));

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
			INT_O <= 1'b0;
		else
			INT_O <= irq_next;
	end

	// read mux; unmapped offsets read zero
	always_comb
	begin
		rd_next = '0;
		unique case (REG_ADDR_I)
			bei_pkg::OFS_CTRL:
			begin
				rd_next[bei_pkg::CTRL_MODE_BIT]  = update_mode_select_reg;
				rd_next[bei_pkg::CTRL_LOCAL_BIT] = local_update_request_reg;
			end
			bei_pkg::OFS_TEI:
			begin
				rd_next[bei_pkg::TEI_RATE_LSB +: bei_pkg::TEI_RATE_W] = insert_rate_field_reg;
				rd_next[bei_pkg::TEI_ENABLE_BIT] = single_insert_enable_reg;
				rd_next[bei_pkg::TEI_TRIG_BIT]   = single_insert_trigger_reg;
				rd_next[bei_pkg::TEI_SRC_BIT]    = insert_source_select_reg;
			end
			bei_pkg::OFS_LIVE:
			begin
				rd_next[bei_pkg::ST_UPDATE_BIT]  = update_done_flag_reg;
				rd_next[bei_pkg::ST_NONZERO_BIT] = error_count_nonzero_reg;
				rd_next[bei_pkg::ST_SYNC_BIT]    = out_of_sync_flag_reg;
			end
			bei_pkg::OFS_LATCH:  rd_next[SW-1:0] = latched_reg;
			bei_pkg::OFS_IRQEN:  rd_next[SW-1:0] = irq_en_reg;
			bei_pkg::OFS_ERR_LO: rd_next = err_snap_reg[DW-1:0];
			bei_pkg::OFS_ERR_HI: rd_next[EW-DW-1:0] = err_snap_reg[EW-1:DW];
			bei_pkg::OFS_BIT_LO: rd_next = bit_snap_reg[DW-1:0];
			bei_pkg::OFS_BIT_HI: rd_next = bit_snap_reg[BW-1:DW];
			default:             rd_next = '0;
		endcase
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			REG_RDATA_O  <= '0;
			REG_RVALID_O <= 1'b0;
		end
		else
		begin
			REG_RVALID_O <= REG_RD_I;
			if (REG_RD_I)
				REG_RDATA_O <= rd_next;
		end
	end

	property p_update_snap;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		upd_pulse |=> (update_done_flag_reg && err_snap_reg == $past(err_acc) && bit_snap_reg == $past(received_bit_total));
	endproperty
	a_update_snap: assert property (p_update_snap) else $error("update did not load snapshot");

	property p_update_low;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		!sel_req |=> !update_done_flag_reg;
	endproperty
	a_update_low: assert property (p_update_low) else $error("done flag high without request");

	property p_snap_hold;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		!upd_pulse |=> ($stable(err_snap_reg) && $stable(bit_snap_reg));
	endproperty
	a_snap_hold: assert property (p_snap_hold) else $error("snapshot changed without update");

	property p_oos_freeze;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		(RX_OUT_OF_SYNC_I && !upd_pulse) |=> ($stable(err_acc) && $stable(received_bit_total));
	endproperty
	a_oos_freeze: assert property (p_oos_freeze) else $error("counted while out of sync");

	property p_sync_latch;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		$changed(out_of_sync_flag_reg) |=> latched_reg[bei_pkg::ST_SYNC_BIT];
	endproperty
	a_sync_latch: assert property (p_sync_latch) else $error("sync change not latched");

	property p_irq_gate;
		@(posedge CORE_CLK_I) disable iff (RST_I)
		(!PORT_GLOBAL_IRQ_EN_I && !(latched_reg[bei_pkg::ST_UPDATE_BIT] && irq_en_reg[bei_pkg::ST_UPDATE_BIT]))
		|=> !INT_O;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without port enable");
endmodule

// ---- verification/bei_far_end.sv ----
// far side model: transmit bit source and receive bit stand-in
`timescale 1ns/1ps
module bei_far_end (
	input  wire logic   clk_i,
	input  wire logic   tx_on_i,
	input  wire logic   rx_on_i,
	input  wire logic   rx_err_i,
	input  wire logic   tx_vld_i,
	input  wire logic   tx_bit_i,
	output logic        tx_valid_o,
	output logic        tx_data_o,
	output logic        rx_valid_o,
	output logic        rx_error_o,
	output logic [15:0] inv_cnt_o
);
	logic        pat_reg = 1'b0;
	logic        sent_reg = 1'b0;
	logic [15:0] cnt_reg = 16'h0000;
	// alternating data so an inversion never hides in a constant stream
	always_ff @(posedge clk_i)
	begin
		pat_reg <= ~pat_reg;
		if (tx_valid_o)
			sent_reg <= tx_data_o;
		if (tx_vld_i && (tx_bit_i !== sent_reg))
			cnt_reg <= cnt_reg + 16'h0001;
	end
	// error line wanders outside slots rather than holding a value
	assign tx_valid_o = tx_on_i;
	assign tx_data_o  = pat_reg;
	assign rx_valid_o = rx_on_i;
	assign rx_error_o = rx_on_i ? rx_err_i : pat_reg;
	assign inv_cnt_o  = cnt_reg;
endmodule

// ---- verification/tb_bei_top.sv ----
// self-checking bench for the bit error tester back end
`timescale 1ns/1ps
module tb_bei_top;
	typedef struct packed
	{
		logic [7:0]  a;
		logic [15:0] w;
		logic [15:0] e;
	} bei_row_s;
	logic        CORE_CLK_I = 1'b0;
	logic        RST_I = 1'b1;
	logic [7:0]  REG_ADDR_I = 8'h00;
	logic [15:0] REG_WDATA_I = 16'h0000;
	logic        REG_WR_I = 1'b0;
	logic        REG_RD_I = 1'b0;
	logic        EXT_I = 1'b0;
	logic        OOS_I = 1'b0;
	logic        GUPD_I = 1'b0;
	logic        PGIE_I = 1'b0;
	logic        tx_on = 1'b0;
	logic        rx_on = 1'b0;
	logic        rx_err = 1'b0;
	logic [15:0] REG_RDATA_O, inv_cnt;
	logic        REG_RVALID_O, TXV_I, TXD_I, TXV_O, TXD_O, RXV_I, RXE_I, INT_O;
	int          bad_count = 0;
	int          compares = 0;
	bei_row_s    rows [5] = '{{8'h70, 16'h000f, 16'h000f}, {8'h74, 16'hffff, 16'h0000},
		{8'h7a, 16'hffff, 16'h0000}, {8'h6a, 16'hffff, 16'h0000}, {8'h70, 16'h0000, 16'h0000}};
	bei_top uut (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
		.REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
		.REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O), .TX_BIT_VALID_I(TXV_I),
		.TX_DATA_I(TXD_I), .TX_BIT_VALID_O(TXV_O), .TX_DATA_O(TXD_O),
		.EXTERNAL_INSERT_INPUT_I(EXT_I), .RX_BIT_VALID_I(RXV_I), .RX_BIT_ERROR_I(RXE_I),
		.RX_OUT_OF_SYNC_I(OOS_I), .GLOBAL_UPDATE_SIGNAL_I(GUPD_I),
		.PORT_GLOBAL_IRQ_EN_I(PGIE_I), .INT_O(INT_O));
	bei_far_end u_far (.clk_i(CORE_CLK_I), .tx_on_i(tx_on), .rx_on_i(rx_on), .rx_err_i(rx_err),
		.tx_vld_i(TXV_O), .tx_bit_i(TXD_O), .tx_valid_o(TXV_I), .tx_data_o(TXD_I),
		.rx_valid_o(RXV_I), .rx_error_o(RXE_I), .inv_cnt_o(inv_cnt));
	// free running core clock
	always #2.5 CORE_CLK_I = ~CORE_CLK_I;
	task automatic cyc(input int n);
		repeat (n) @(posedge CORE_CLK_I);
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge CORE_CLK_I);
		REG_WR_I <= 1'b1;
		REG_ADDR_I <= a;
		REG_WDATA_I <= d;
		@(posedge CORE_CLK_I);
		REG_WR_I <= 1'b0;
	endtask
	// sample after the answer edge settles, then realign to an edge
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge CORE_CLK_I);
		REG_RD_I <= 1'b1;
		REG_ADDR_I <= a;
		@(posedge CORE_CLK_I);
		REG_RD_I <= 1'b0;
		#1;
		chk({15'h0000, REG_RVALID_O}, 16'h0001);
		chk(REG_RDATA_O, e);
		@(posedge CORE_CLK_I);
	endtask
	task automatic ichk(input logic [15:0] e);
		cyc(3);
		#1;
		chk({15'h0000, INT_O}, e);
		@(posedge CORE_CLK_I);
	endtask
	// n transmit slots back to back, then count inversions seen
	task automatic tx_run(input int n, input logic [15:0] e);
		logic [15:0] b;
		b = inv_cnt;
		@(posedge CORE_CLK_I);
		tx_on <= 1'b1;
		cyc(n);
		tx_on <= 1'b0;
		cyc(3);
		chk(inv_cnt - b, e);
	endtask
	task automatic rx_run(input int n);
		@(posedge CORE_CLK_I);
		rx_on <= 1'b1;
		cyc(n);
		rx_on <= 1'b0;
		cyc(2);
	endtask
	task automatic end_sim();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// hang guard
	initial
	begin
		#100000;
		bad_count++;
		end_sim();
	end
	initial
	begin
		cyc(6);
		RST_I <= 1'b0;
		rd(8'h74, 16'h0000);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e);
		end
		wr(8'h68, 16'h0008);
		tx_run(100, 16'h000a);
		wr(8'h68, 16'h0010);
		tx_run(110, 16'h0002);
		wr(8'h68, 16'h0000);
		tx_run(30, 16'h0000);
		wr(8'h68, 16'h0002);
		tx_run(5, 16'h0000);
		wr(8'h68, 16'h0004);
		wr(8'h68, 16'h0006);
		tx_run(5, 16'h0001);
		wr(8'h68, 16'h0004);
		wr(8'h68, 16'h0006);
		wr(8'h68, 16'h0004);
		wr(8'h68, 16'h0006);
		tx_run(5, 16'h0001);
		wr(8'h68, 16'h0004);
		wr(8'h68, 16'h0005);
		EXT_I <= 1'b1;
		cyc(6);
		EXT_I <= 1'b0;
		cyc(2);
		tx_run(5, 16'h0001);
		wr(8'h68, 16'h0007);
		tx_run(5, 16'h0000);
		rx_err <= 1'b1;
		rx_run(20);
		rd(8'h6c, 16'h0002);
		wr(8'h60, 16'h0040);
		cyc(2);
		rd(8'h6c, 16'h0008);
		rd(8'h74, 16'h0014);
		rd(8'h76, 16'h0000);
		rd(8'h78, 16'h0014);
		rd(8'h7a, 16'h0000);
		rd(8'h6e, 16'h000e);
		wr(8'h6e, 16'h000e);
		rd(8'h6e, 16'h0000);
		rx_run(5);
		rd(8'h74, 16'h0014);
		wr(8'h60, 16'h0000);
		cyc(2);
		rd(8'h6c, 16'h0002);
		OOS_I <= 1'b1;
		cyc(3);
		rd(8'h6c, 16'h0003);
		rx_run(7);
		wr(8'h60, 16'h0080);
		GUPD_I <= 1'b1;
		cyc(4);
		rd(8'h78, 16'h0005);
		rd(8'h74, 16'h0005);
		rd(8'h6e, 16'h000f);
		ichk(16'h0000);
		wr(8'h70, 16'h0004);
		ichk(16'h0000);
		PGIE_I <= 1'b1;
		ichk(16'h0001);
		wr(8'h70, 16'h0008);
		PGIE_I <= 1'b0;
		ichk(16'h0001);
		wr(8'h6e, 16'h000f);
		ichk(16'h0000);
		GUPD_I <= 1'b0;
		OOS_I <= 1'b0;
		cyc(3);
		GUPD_I <= 1'b1;
		cyc(4);
		rd(8'h78, 16'h0000);
		rd(8'h6e, 16'h0009);
		ichk(16'h0001);
		RST_I <= 1'b1;
		cyc(2);
		RST_I <= 1'b0;
		rd(8'h70, 16'h0000);
		ichk(16'h0000);
		end_sim();
	end
endmodule
